// ### can_status_pkg.sv
package can_status_pkg;

    // ==========================================================
    // register map, byte addresses on the peripheral bus
    // ==========================================================
    localparam logic [7:0] ADDR_GSW       = 8'h00;
    localparam logic [7:0] ADDR_MODE      = 8'h04;
    localparam logic [7:0] ADDR_INT_STAT  = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK  = 8'h0c;

    // ==========================================================
    // global status word layout
    // ==========================================================
    localparam int TX_TALLY_LSB  = 24;
    localparam int RX_TALLY_LSB  = 16;
    localparam int BUS_OFF_BIT   = 7;

    // ==========================================================
    // mode register and interrupt layout
    // ==========================================================
    localparam int SOFT_RESET_BIT = 0;
    localparam int INT_WARN_BIT   = 0;
    localparam int INT_BUS_ON_BIT = 1;
    localparam int INT_WIDTH      = 2;

    // ==========================================================
    // reset values and fault confinement figures
    // ==========================================================
    localparam logic [7:0] TALLY_RESET      = 8'h00;
    localparam logic [7:0] TX_BUS_OFF_LOAD  = 8'h7f;
    localparam logic [7:0] TX_LIMIT         = 8'hff;
    localparam logic [7:0] TX_WRITE_MAX     = 8'hfe;
    localparam logic [7:0] ERR_STEP_BIG     = 8'h08;
    localparam logic [7:0] ERR_STEP_ONE     = 8'h01;
    localparam logic [7:0] RX_PASSIVE_TOP   = 8'h7f;
    localparam logic [7:0] RX_REENTRY       = 8'h77;
    localparam logic       SOFT_RESET_INIT  = 1'b1;
    localparam logic [1:0] INT_MASK_INIT    = 2'h0;

    // ==========================================================
    // bus idle detection
    // ==========================================================
    localparam int         IDLE_BITS        = 11;
    localparam logic [3:0] IDLE_BITS_CNT    = 4'hb;

    typedef enum {
        ST_SOFT_RESET,
        ST_WAIT_ONE_IDLE,
        ST_RECOVER,
        ST_ACTIVE
    } link_state_t;

endpackage

// ### bus_idle_detect.sv
`timescale 1ns/100ps
`default_nettype none

module bus_idle_detect
    import can_status_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic bit_tick,
    input  wire logic rx_level,
    output logic      idle_pulse
);

    typedef struct packed {
        logic [3:0] run;
        logic       pulse;
    } idle_state_t;

    idle_state_t cur_ff;
    idle_state_t nxt_cur;

    // ==========================================================
    // count consecutive recessive samples
    // ==========================================================
    // one pulse per 11 recessive bits; the run then restarts so a
    // quiet bus keeps producing pulses for the recovery count
    always_comb begin
        nxt_cur       = cur_ff;
        nxt_cur.pulse = 1'b0;
        if (bit_tick) begin
            if (!rx_level) begin
                nxt_cur.run = 4'h0;
            end else if (cur_ff.run == IDLE_BITS_CNT - 4'h1) begin
                nxt_cur.run   = 4'h0;
                nxt_cur.pulse = 1'b1;
            end else begin
                nxt_cur.run = cur_ff.run + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign idle_pulse = cur_ff.pulse;

endmodule // bus_idle_detect

`default_nettype wire

// ### can_fault_status.sv
// What this block does
// - transmit tally lives in status word bits 31..24, zero after reset.
// - receive tally lives in bits 23..16, zero after reset.
// - software writes to either tally only land in soft reset mode.
// - bus-off loads transmit tally with 127; it times 128 idle periods.
// - transmit tally stays readable during recovery to show progress.
// - bus-off clears receive tally.
// - receive tally writes ignored while bus-off holds.
// - writing 0..254 to transmit tally while bus-off clears bus-off.
// - after that, one idle period of 11 recessive bits before rejoin.
// - bus-off flag bit 7, read-only, set at FFh, stops bus activity.
// - status bits 15..8 read zero and ignore writes.
// - reaching 255 enters bus-off, forces soft reset, warning interrupt.
// - recovery end clears bus-off, resets tallies, warning interrupt.
`timescale 1ns/100ps
`default_nettype none

module can_fault_status
    import can_status_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        can_rx,
    input  wire logic        bit_tick,
    input  wire logic        tx_error,
    input  wire logic        tx_success,
    input  wire logic        rx_error,
    input  wire logic        rx_error_severe,
    input  wire logic        rx_success,
    output logic             bus_enable,
    output logic             bus_off_flag,
    output logic             soft_reset_mode,
    output logic             irq
);

    import can_status_pkg::*;

    typedef struct packed {
        logic [1:0]       rx_sync;
        logic [7:0]       tx_fault_tally;
        logic [7:0]       rx_fault_tally;
        logic             bus_off;
        logic             soft_reset;
        logic             recover_pending;
        logic [INT_WIDTH-1:0] int_stat;
        logic [INT_WIDTH-1:0] int_mask;
        link_state_t      state;
        logic [31:0]      rdata;
        logic             err;
        logic             en;
        logic             irq;
    } core_state_t;

    core_state_t cur_ff;
    core_state_t nxt_cur;
    logic        idle_pulse;
    logic        idle_tick;
    logic        idle_level;

    // ==========================================================
    // idle detector on the synchronised receive level
    // ==========================================================
    // soft reset holds the run at zero every cycle, so the idle wait
    // that follows never counts recessive bits seen before it
    assign idle_tick  = bit_tick || cur_ff.soft_reset;
    assign idle_level = cur_ff.rx_sync[1] && !cur_ff.soft_reset;

    bus_idle_detect u_idle (
        .pclk       (pclk),
        .presetn    (presetn),
        .bit_tick   (idle_tick),
        .rx_level   (idle_level),
        .idle_pulse (idle_pulse)
    );

    // ==========================================================
    // tally helpers: 9-bit sum with carry out, decrement held at zero
    // ==========================================================
    function automatic logic [8:0] add_sat9(input logic [7:0] a,
                                            input logic [7:0] b);
        add_sat9 = {1'b0, a} + {1'b0, b};
    endfunction

    function automatic logic [7:0] dec_floor(input logic [7:0] a);
        dec_floor = (a == TALLY_RESET) ? TALLY_RESET : a - ERR_STEP_ONE;
    endfunction

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        logic        setup;
        logic        access;
        logic        wr_gsw;
        logic        wr_mode;
        logic        wr_mask;
        logic        rd_stat;
        logic [8:0]  tx_sum;
        logic [8:0]  rx_sum;
        logic [7:0]  wr_tx;
        logic [7:0]  wr_rx;
        logic [INT_WIDTH-1:0] ev;
        setup   = 1'b0;
        access  = 1'b0;
        wr_gsw  = 1'b0;
        wr_mode = 1'b0;
        wr_mask = 1'b0;
        rd_stat = 1'b0;
        tx_sum  = 9'h000;
        rx_sum  = 9'h000;
        wr_tx   = 8'h00;
        wr_rx   = 8'h00;
        ev      = '0;
        nxt_cur = cur_ff;

        // pin level passes two flops before the detector reads it
        nxt_cur.rx_sync = {cur_ff.rx_sync[0], can_rx};

        setup   = psel && !penable;
        access  = psel && penable;
        wr_gsw  = access && pwrite && (paddr == ADDR_GSW);
        wr_mode = access && pwrite && (paddr == ADDR_MODE);
        wr_mask = access && pwrite && (paddr == ADDR_INT_MASK);
        rd_stat = access && !pwrite && (paddr == ADDR_INT_STAT);
        wr_tx   = pwdata[TX_TALLY_LSB +: 8];
        wr_rx   = pwdata[RX_TALLY_LSB +: 8];

        // ------------------------------------------------------
        // fault confinement while taking part in bus traffic
        // ------------------------------------------------------
        // nothing is counted in soft reset, where software owns tallies
        if (cur_ff.state == ST_ACTIVE && !cur_ff.soft_reset) begin
            tx_sum = {1'b0, cur_ff.tx_fault_tally};
            if (tx_error) begin
                tx_sum = add_sat9(cur_ff.tx_fault_tally, ERR_STEP_BIG);
            end else if (tx_success) begin
                tx_sum = {1'b0, dec_floor(cur_ff.tx_fault_tally)};
            end
            rx_sum = {1'b0, cur_ff.rx_fault_tally};
            if (rx_error_severe) begin
                rx_sum = add_sat9(cur_ff.rx_fault_tally, ERR_STEP_BIG);
            end else if (rx_error) begin
                rx_sum = add_sat9(cur_ff.rx_fault_tally, ERR_STEP_ONE);
            end else if (rx_success) begin
                if (cur_ff.rx_fault_tally > RX_PASSIVE_TOP) begin
                    rx_sum = {1'b0, RX_REENTRY};
                end else begin
                    rx_sum = {1'b0, dec_floor(cur_ff.rx_fault_tally)};
                end
            end
            // receive tally sticks at its top instead of wrapping
            nxt_cur.rx_fault_tally = rx_sum[8] ? TX_LIMIT : rx_sum[7:0];
            if (rx_sum[8]) begin
                nxt_cur.rx_fault_tally = TX_LIMIT;
            end
            // reaching FFh or beyond is bus-off
            if (tx_sum[8] || tx_sum[7:0] == TX_LIMIT) begin
                nxt_cur.bus_off         = 1'b1;
                nxt_cur.soft_reset      = 1'b1;
                nxt_cur.recover_pending = 1'b1;
                nxt_cur.tx_fault_tally  = TX_BUS_OFF_LOAD;
                nxt_cur.rx_fault_tally  = TALLY_RESET;
                nxt_cur.state           = ST_SOFT_RESET;
                ev[INT_WARN_BIT]        = 1'b1;
            end else begin
                nxt_cur.tx_fault_tally = tx_sum[7:0];
            end
        end

        // ------------------------------------------------------
        // link state sequencing
        // ------------------------------------------------------
        case (cur_ff.state)
            ST_SOFT_RESET: begin
                if (!cur_ff.soft_reset) begin
                    nxt_cur.state = cur_ff.recover_pending ?
                                    ST_RECOVER : ST_WAIT_ONE_IDLE;
                end
                // a stored FFh must not stretch recovery past 128 idles
                if (!cur_ff.soft_reset && cur_ff.recover_pending) begin
                    nxt_cur.tx_fault_tally = TX_BUS_OFF_LOAD;
                end
            end
            ST_WAIT_ONE_IDLE: begin
                if (idle_pulse) begin
                    nxt_cur.state = ST_ACTIVE;
                end
            end
            ST_RECOVER: begin
                // tally counts down 127..0, one more idle ends it
                if (idle_pulse) begin
                    if (cur_ff.tx_fault_tally == TALLY_RESET) begin
                        nxt_cur.state           = ST_ACTIVE;
                        nxt_cur.bus_off         = 1'b0;
                        nxt_cur.recover_pending = 1'b0;
                        nxt_cur.tx_fault_tally  = TALLY_RESET;
                        nxt_cur.rx_fault_tally  = TALLY_RESET;
                        ev[INT_WARN_BIT]        = 1'b1;
                        ev[INT_BUS_ON_BIT]      = 1'b1;
                    end else begin
                        nxt_cur.tx_fault_tally =
                            cur_ff.tx_fault_tally - ERR_STEP_ONE;
                    end
                end
            end
            ST_ACTIVE: begin
                if (cur_ff.soft_reset) begin
                    nxt_cur.state = ST_SOFT_RESET;
                end
            end
            default: begin
                nxt_cur.state = ST_SOFT_RESET;
            end
        endcase

        // ------------------------------------------------------
        // software writes
        // ------------------------------------------------------
        // error counting stops in soft reset, so the only writer
        // in that mode is software
        if (wr_gsw && cur_ff.soft_reset) begin
            nxt_cur.tx_fault_tally = wr_tx;
            if (!cur_ff.bus_off) begin
                nxt_cur.rx_fault_tally = wr_rx;
            end
            if (cur_ff.bus_off && wr_tx <= TX_WRITE_MAX) begin
                nxt_cur.bus_off         = 1'b0;
                nxt_cur.recover_pending = 1'b0;
            end
        end
        if (wr_mode) begin
            nxt_cur.soft_reset = pwdata[SOFT_RESET_BIT];
        end
        if (wr_mask) begin
            nxt_cur.int_mask = pwdata[INT_WIDTH-1:0];
        end

        // ------------------------------------------------------
        // read data captured in setup, so no wait state is needed
        // ------------------------------------------------------
        if (setup) begin
            nxt_cur.rdata = 32'h0000_0000;
            nxt_cur.err   = 1'b0;
            case (paddr)
                ADDR_GSW: begin
                    nxt_cur.rdata[TX_TALLY_LSB +: 8] =
                        cur_ff.tx_fault_tally;
                    nxt_cur.rdata[RX_TALLY_LSB +: 8] =
                        cur_ff.rx_fault_tally;
                    nxt_cur.rdata[BUS_OFF_BIT] = cur_ff.bus_off;
                end
                ADDR_MODE: begin
                    nxt_cur.rdata[SOFT_RESET_BIT] = cur_ff.soft_reset;
                end
                ADDR_INT_STAT: begin
                    nxt_cur.rdata[INT_WIDTH-1:0] = cur_ff.int_stat;
                end
                ADDR_INT_MASK: begin
                    nxt_cur.rdata[INT_WIDTH-1:0] = cur_ff.int_mask;
                end
                default: begin
                    nxt_cur.err = 1'b1;
                end
            endcase
        end

        // ------------------------------------------------------
        // interrupt status
        // ------------------------------------------------------
        // a read clears only the bits that it reported, so an event
        // that lands between setup and access is still seen later
        if (rd_stat) begin
            nxt_cur.int_stat = cur_ff.int_stat
                               & ~cur_ff.rdata[INT_WIDTH-1:0];
        end
        // a new event in the same cycle as the read survives it
        nxt_cur.int_stat = nxt_cur.int_stat | ev;

        // ------------------------------------------------------
        // registered outputs, taken from the next state so they
        // move on the same edge as the state they report
        // ------------------------------------------------------
        // no bus activity while bus-off, in soft reset or not rejoined
        nxt_cur.en  = (nxt_cur.state == ST_ACTIVE)
                      && !nxt_cur.bus_off
                      && !nxt_cur.soft_reset;
        nxt_cur.irq = |(nxt_cur.int_stat & nxt_cur.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff                 <= '0;
            cur_ff.tx_fault_tally  <= TALLY_RESET;
            cur_ff.rx_fault_tally  <= TALLY_RESET;
            cur_ff.soft_reset      <= SOFT_RESET_INIT;
            cur_ff.int_mask        <= INT_MASK_INIT;
            cur_ff.state           <= ST_SOFT_RESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign prdata          = cur_ff.rdata;
    assign pslverr         = cur_ff.err && psel && penable;
    assign pready          = 1'b1;
    assign bus_enable      = cur_ff.en;
    assign bus_off_flag    = cur_ff.bus_off;
    assign soft_reset_mode = cur_ff.soft_reset;
    assign irq             = cur_ff.irq;

endmodule // can_fault_status

`default_nettype wire

// ### can_fault_status_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// status block checks
module can_fault_status_checker
    import can_status_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bus_enable,
    input wire logic        bus_off_flag,
    input wire logic        soft_reset_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd;
        psel && !penable && !pwrite && paddr == ADDR_GSW;
    endsequence
    sequence s_unmapped;
        psel && penable && (paddr > ADDR_INT_MASK || paddr[1:0] != 2'h0);
    endsequence
    property p_rdy; psel && penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("access without ready");
    property p_err; s_unmapped |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped without error");
    property p_be_off; bus_off_flag |-> !bus_enable; endproperty
    a_be_off: assert property (p_be_off)
        else $error("bus enabled while off");
    property p_enter; $rose(bus_off_flag) |-> soft_reset_mode; endproperty
    a_enter: assert property (p_enter)
        else $error("bus off without soft reset");
    property p_bo_rd; s_rd |=> prdata[BUS_OFF_BIT] == $past(bus_off_flag);
    endproperty
    a_bo_rd: assert property (p_bo_rd)
        else $error("status flag read wrong");
    property p_rsv; s_rd |=> prdata[15:8] == 8'h00; endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved byte not zero");
    property p_rx_bo; s_rd ##0 bus_off_flag |=> prdata[23:16] == 8'h00;
    endproperty
    a_rx_bo: assert property (p_rx_bo)
        else $error("rx tally nonzero while off");
    property p_rejoin; $fell(soft_reset_mode) |=> !bus_enable [*8];
    endproperty
    a_rejoin: assert property (p_rejoin)
        else $error("rejoined without idle wait");
    property p_exit;
        $fell(bus_off_flag) && !soft_reset_mode |-> ##[0:2] bus_enable;
    endproperty
    a_exit: assert property (p_exit)
        else $error("no rejoin after recovery");
    property p_sr_be; soft_reset_mode [*2] |-> !bus_enable; endproperty
    a_sr_be: assert property (p_sr_be)
        else $error("bus enabled in soft reset");
endmodule // can_fault_status_checker

bind can_fault_status can_fault_status_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_enable(bus_enable),
    .bus_off_flag(bus_off_flag), .soft_reset_mode(soft_reset_mode));
`default_nettype wire

// ### can_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// bus side: bit timing and receive level
module can_bus_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic hold_dominant,
    output logic      bit_tick,
    output logic      can_rx
);
    logic [1:0] div_ff;
    // short bit time keeps 128 idle periods cheap to simulate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff   <= 2'h0;
            bit_tick <= 1'b0;
            can_rx   <= 1'b1;
        end else begin
            div_ff   <= div_ff + 2'h1;
            bit_tick <= (div_ff == 2'h3);
            can_rx   <= !hold_dominant;
        end
    end
endmodule // can_bus_model
`default_nettype wire

// ### tb_can_fault_status.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
// ====================
// status block bench
module tb_can_fault_status;
    import can_status_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  ev;
    logic        bit_tick, can_rx, bus_enable, bus_off_flag, irq, dom, e;
    logic        soft_reset_mode;
    int          err_count, num_checks;
    can_fault_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .can_rx(can_rx), .bit_tick(bit_tick), .tx_error(ev[4]),
        .tx_success(ev[3]), .rx_error(ev[2]), .rx_error_severe(ev[1]),
        .rx_success(ev[0]), .bus_enable(bus_enable),
        .bus_off_flag(bus_off_flag), .soft_reset_mode(soft_reset_mode),
        .irq(irq));
    can_bus_model u_bus (.pclk(pclk), .presetn(presetn),
        .hold_dominant(dom), .bit_tick(bit_tick), .can_rx(can_rx));
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask
    task automatic fire(input logic [4:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 5'h00;
    endtask
    task automatic wait_on(input int n);
        for (int i = 0; i < n && bus_enable !== 1'b1; i++) @(negedge pclk);
        `CHK(bus_enable, 1'b1)
    endtask
    task automatic t_reset;
        rdc(ADDR_GSW, 32'h0);
        rdc(ADDR_MODE, 32'h1);
        `CHK(irq, 1'b0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(e, 1'b1)
    endtask
    task automatic t_soft;
        // flag written nonzero on purpose; reserved byte kept zero
        apb(1'b1, ADDR_GSW, 32'h12340080);
        rdc(ADDR_GSW, 32'h12340000);
        apb(1'b1, ADDR_MODE, 32'h0);
        wait_on(100);
        apb(1'b1, ADDR_GSW, 32'h55660000);
        rdc(ADDR_GSW, 32'h12340000);
        fire(5'h10);
        fire(5'h08);
        fire(5'h04);
        fire(5'h02);
        fire(5'h01);
        rdc(ADDR_GSW, 32'h193c0000);
        fire(5'h14);
        rdc(ADDR_GSW, 32'h213d0000);
    endtask
    task automatic to_off;
        apb(1'b1, ADDR_MODE, 32'h1);
        apb(1'b1, ADDR_GSW, 32'hf8050000);
        apb(1'b1, ADDR_MODE, 32'h0);
        wait_on(100);
        fire(5'h10);
        rdc(ADDR_GSW, 32'h7f000080);
        `CHK(soft_reset_mode & ~bus_enable, 1'b1)
        `CHK(bus_off_flag, 1'b1)
    endtask
    task automatic t_off1;
        to_off;
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        rdc(ADDR_INT_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_GSW, 32'hff330000);
        rdc(ADDR_GSW, 32'hff000080);
        apb(1'b1, ADDR_GSW, 32'h10000000);
        rdc(ADDR_GSW, 32'h10000000);
        dom <= 1'b1;
        apb(1'b1, ADDR_MODE, 32'h0);
        repeat (200) @(posedge pclk);
        `CHK(bus_enable, 1'b0)
        dom <= 1'b0;
        wait_on(100);
    endtask
    task automatic t_off2;
        to_off;
        `CHK(irq, 1'b1)
        rdc(ADDR_INT_STAT, 32'h1);
        // a stored FFh keeps bus-off and must not stretch recovery
        apb(1'b1, ADDR_GSW, 32'hff000000);
        rdc(ADDR_GSW, 32'hff000080);
        apb(1'b1, ADDR_MODE, 32'h0);
        repeat (2800) @(posedge pclk);
        apb(1'b0, ADDR_GSW, 32'h0);
        `CHK(q[31:24] < 8'h7f && q[31:24] > 8'h00 && q[7], 1'b1)
        wait_on(4000);
        rdc(ADDR_GSW, 32'h0);
        rdc(ADDR_INT_STAT, 32'h3);
    endtask
    task automatic t_rst2;
        apb(1'b1, ADDR_MODE, 32'h1);
        apb(1'b1, ADDR_GSW, 32'h22110000);
        rdc(ADDR_GSW, 32'h22110000);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADDR_GSW, 32'h0);
        rdc(ADDR_MODE, 32'h1);
        rdc(ADDR_INT_MASK, 32'h0);
        `CHK(bus_enable | irq, 1'b0)
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        give_verdict;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ev = 5'h00;
        dom = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_soft;
        t_off1;
        t_off2;
        t_rst2;
        give_verdict;
    end
endmodule // tb_can_fault_status
`default_nettype wire
